// file: logic/fdhp_port.v
// Functional notes
// - Standard mode decodes 13 address bits, strobes.
// - Address bit zero doubles as deep sleep request.
// - Width strap low means 8-bit, high 16-bit.
// - Ready-wait held low after reset until ready.
// - Active-low transfer request paces DMA.
// - Key-guard low refuses key-based partition opening.
// - Clock used only for burst flash reads.
// - Multiplexed mode: shared bus, strobe on strap.
// - Falling edge on upper strap enters multiplexed.
// - Standard mode position from straps, 00 first.
// - Multiplexed mode forces upper position bit zero.
// - Dual-die variant cannot cascade in multiplexed mode.
// - Software selects interrupt event source.
// - Interrupt output is edge or level.
// - Device acts on strobe transitions.
// - 8-bit mode routes odd/even bytes low.
// - Ready-wait released when boot loading completes.
`include "fdhp_regs.vh"
`default_nettype none
module fdhp_port #(
   parameter AW       = `FDHP_AW,
   parameter DW       = `FDHP_DW,
   parameter LOAD_NS  = `FDHP_LOAD_NS,
   parameter DUAL_DIE = 0
) (
   // Clock and reset
   input  wire          clk,
   input  wire          rst,
   input  wire          power_on_reset_n,
   // Host bus pins
   input  wire [AW-1:0] addr_pins,
   input  wire [DW-1:0] data_in,
   output reg  [DW-1:0] data_out,
   output reg           data_oe_n,
   input  wire          chip_select_n,
   input  wire          read_strobe_n,
   input  wire          write_strobe_n,
   input  wire          burst_clk,
   // Straps
   input  wire          bus_width_16,
   input  wire [1:0]    cascade_position_straps,
   input  wire          key_guard,
   // Status pins
   output reg           ready_wait_n,
   output reg           transfer_request_n,
   output reg           irq_n,
   // Core side
   input  wire          load_done,
   input  wire          dma_req,
   input  wire [DW-1:0] core_rdata,
   input  wire [1:0]    irq_source_sel,
   input  wire          irq_level_mode,
   input  wire          irq_ack,
   input  wire          ev_flash_ready,
   input  wire          ev_protection,
   input  wire          ev_dma_last,
   input  wire          ev_ecc_error,
   input  wire [1:0]    target_position,
   output reg  [AW-1:0] core_addr,
   output reg  [DW-1:0] core_wdata,
   output reg           core_rd,
   output reg           core_wr,
   output reg           burst_tick,
   output reg           deep_sleep_ctl,
   output reg           key_open_allowed,
   output reg           mux_mode,
   output reg           wide_mode
);
   // ----------------------------------------
   // Timing and state.
   // ----------------------------------------
   localparam integer LOAD_CYC_RAW = (LOAD_NS + `FDHP_CLK_NS - 1) / `FDHP_CLK_NS;
   localparam integer LOAD_CYC     = (LOAD_CYC_RAW < 1) ? 1 : LOAD_CYC_RAW;
   localparam [15:0]  LOAD_LAST    = LOAD_CYC[15:0];
   localparam [1:0] ST_RESET = 2'h0;
   localparam [1:0] ST_LOAD  = 2'h1;
   localparam [1:0] ST_READY = 2'h2;
   // Strobes and the burst clock start idle high; the power-on pin and the upper strap
   // start low, so reset is followed by neither a false release nor a false strobe edge.
   localparam [5:0] CTL_INIT = 6'h3C;

   // ----------------------------------------
   // Input synchronisers.
   // ----------------------------------------
   wire [5:0]    ctl_s;
   wire [AW-1:0] addr_s;
   wire [DW-1:0] data_s;
   wire [2:0]    sig_s;
   // One synchroniser for all strobes keeps their edges aligned with each other.
   fdhp_sync #(.W(6), .INIT(CTL_INIT)) u_ctl (
      .clk (clk),
      .rst (rst),
      .d   ({chip_select_n, read_strobe_n, write_strobe_n, burst_clk,
             cascade_position_straps[1], power_on_reset_n}),
      .q   (ctl_s)
   );
   fdhp_sync #(.W(AW)) u_addr (
      .clk (clk),
      .rst (rst),
      .d   (addr_pins),
      .q   (addr_s)
   );
   fdhp_sync #(.W(DW)) u_data (
      .clk (clk),
      .rst (rst),
      .d   (data_in),
      .q   (data_s)
   );
   fdhp_sync #(.W(3)) u_strap (
      .clk (clk),
      .rst (rst),
      .d   ({bus_width_16, cascade_position_straps[0], key_guard}),
      .q   (sig_s)
   );
   wire cs_n_s  = ctl_s[5];
   wire rd_n_s  = ctl_s[4];
   wire wr_n_s  = ctl_s[3];
   wire bclk_s  = ctl_s[2];
   wire id1_s   = ctl_s[1];
   wire por_n_s = ctl_s[0];

   // ----------------------------------------
   // Previous samples for edge detection.
   // ----------------------------------------
   reg       cs_n_q;
   reg       rd_n_q;
   reg       wr_n_q;
   reg       bclk_q;
   reg       id1_q;
   reg [1:0] st_q;
   reg [15:0] load_cnt_q;
   reg [AW-1:0] lat_addr_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         bclk_q <= 1'b1;
         id1_q  <= 1'b0;
      end else begin
         cs_n_q <= cs_n_s;
         rd_n_q <= rd_n_s;
         wr_n_q <= wr_n_s;
         bclk_q <= bclk_s;
         id1_q  <= id1_s;
      end
   end
   // A read, write or burst clock edge is only a bus event while chip select is low.
   wire rd_fall  = rd_n_q & ~rd_n_s & ~cs_n_s;
   wire wr_rise  = ~wr_n_q & wr_n_s & ~cs_n_s;
   wire cs_fall  = cs_n_q & ~cs_n_s;
   wire avd_fall = id1_q & ~id1_s;
   wire bclk_up  = ~bclk_q & bclk_s;

   // ----------------------------------------
   // Mode, position and reset sequencing.
   // ----------------------------------------
   // In multiplexed mode the upper strap is the address-valid strobe, not a position bit.
   wire [1:0] my_pos = mux_mode ? {1'b0, sig_s[1]} : {id1_s, sig_s[1]};
   wire       cascade_ok = ~(mux_mode && DUAL_DIE != 0) || (my_pos == 2'h0);
   wire       selected   = (my_pos == target_position) && cascade_ok;
   wire       active     = (st_q == ST_READY) && selected && ~cs_n_s;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q         <= ST_RESET;
         load_cnt_q   <= 16'h0000;
         mux_mode     <= 1'b0;
         ready_wait_n <= 1'b0;
      end else if (!por_n_s) begin
         // Power-on pin low restarts loading and leaves multiplexed mode.
         st_q         <= ST_RESET;
         load_cnt_q   <= 16'h0000;
         mux_mode     <= 1'b0;
         ready_wait_n <= 1'b0;
      end else begin
         if (avd_fall) begin
            mux_mode <= 1'b1;
         end
         case (st_q)
            ST_RESET: begin
               st_q <= ST_LOAD;
            end
            ST_LOAD: begin
               if (load_cnt_q < LOAD_LAST) begin
                  load_cnt_q <= load_cnt_q + 16'h0001;
               end
               if (load_done && load_cnt_q >= LOAD_LAST) begin
                  st_q         <= ST_READY;
                  ready_wait_n <= 1'b1;
               end
            end
            ST_READY: begin
               ready_wait_n <= 1'b1;
            end
            default: begin
               st_q <= ST_RESET;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Address capture and access decode.
   // ----------------------------------------
   // The shared lines carry the address while the address-valid strobe is low.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lat_addr_q <= {AW{1'b0}};
      end else if (mux_mode && ~id1_s) begin
         lat_addr_q <= data_s[AW-1:0];
      end
   end
   wire [AW-1:0] eff_addr = mux_mode ? lat_addr_q : addr_s;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         core_addr        <= {AW{1'b0}};
         core_wdata       <= {DW{1'b0}};
         core_rd          <= 1'b0;
         core_wr          <= 1'b0;
         burst_tick       <= 1'b0;
         deep_sleep_ctl   <= 1'b0;
         key_open_allowed <= 1'b0;
         wide_mode        <= 1'b0;
         data_out         <= {DW{1'b0}};
         data_oe_n        <= 1'b1;
         transfer_request_n <= 1'b1;
      end else begin
         wide_mode        <= sig_s[2];
         key_open_allowed <= sig_s[0];
         // Address bit zero outside a selected cycle is the sleep request.
         if (cs_n_s) begin
            deep_sleep_ctl <= addr_s[0];
         end
         transfer_request_n <= ~(dma_req && st_q == ST_READY);
         core_rd    <= active && (rd_fall || (cs_fall && ~rd_n_s));
         core_wr    <= active && wr_rise;
         // Burst clock rises count only inside a selected read.
         burst_tick <= active && ~rd_n_s && bclk_up;
         if (active) begin
            core_addr <= eff_addr;
         end
         if (active && wr_rise) begin
            if (sig_s[2]) begin
               core_wdata <= data_s;
            end else if (eff_addr[0]) begin
               core_wdata <= {data_s[`FDHP_LO_MSB:0], {(DW/2){1'b0}}};
            end else begin
               core_wdata <= {{(DW/2){1'b0}}, data_s[`FDHP_LO_MSB:0]};
            end
         end
         // In 8-bit mode either byte lane leaves on the low eight data lines.
         if (active && ~rd_n_s) begin
            data_oe_n <= 1'b0;
            if (sig_s[2]) begin
               data_out <= core_rdata;
            end else if (eff_addr[0]) begin
               data_out <= {{(DW/2){1'b0}},
                            core_rdata[`FDHP_HI_MSB:`FDHP_HI_LSB]};
            end else begin
               data_out <= {{(DW/2){1'b0}}, core_rdata[`FDHP_LO_MSB:0]};
            end
         end else begin
            data_oe_n <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Interrupt output.
   // ----------------------------------------
   // The output is registered once more so the pin comes straight from a flop.
   wire irq_raw_n;
   fdhp_irq u_irq (
      .clk            (clk),
      .rst            (rst),
      .irq_source_sel (irq_source_sel),
      .irq_level_mode (irq_level_mode),
      .irq_ack        (irq_ack),
      .ev_flash_ready (ev_flash_ready),
      .ev_protection  (ev_protection),
      .ev_dma_last    (ev_dma_last),
      .ev_ecc_error   (ev_ecc_error),
      .irq_n          (irq_raw_n)
   );
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= irq_raw_n;
      end
   end
endmodule // fdhp_port
`default_nettype wire

// file: logic/fdhp_regs.vh
`ifndef FDHP_REGS_VH
`define FDHP_REGS_VH
// ----------------------------------------
// Address, straps and timing constants.
// ----------------------------------------
`define FDHP_AW            13
`define FDHP_DW            16
`define FDHP_POS_W         2
`define FDHP_LOAD_NS       2000
`define FDHP_CLK_NS        10
`define FDHP_IRQ_PULSE     4'h4
`define FDHP_SRC_READY     2'h0
`define FDHP_SRC_PROT      2'h1
`define FDHP_SRC_DMA_LAST  2'h2
`define FDHP_SRC_ECC_ERR   2'h3
`define FDHP_HI_MSB        15
`define FDHP_HI_LSB        8
`define FDHP_LO_MSB        7
`endif

// file: logic/fdhp_sync.v
`default_nettype none
// ----------------------------------------
// Three-stage input synchroniser with agreement of the last two stages.
// ----------------------------------------
module fdhp_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst,
   // Data
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   genvar i;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               q[i] <= INIT[i];
            end else if (s2_q[i] == s3_q[i]) begin
               q[i] <= s3_q[i];
            end
         end
      end
   endgenerate
endmodule // fdhp_sync
`default_nettype wire

// file: logic/fdhp_irq.v
`include "fdhp_regs.vh"
`default_nettype none
// ----------------------------------------
// Interrupt source select and output sensitivity.
// ----------------------------------------
module fdhp_irq (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Configuration
   input  wire [1:0] irq_source_sel,
   input  wire       irq_level_mode,
   input  wire       irq_ack,
   // Events
   input  wire       ev_flash_ready,
   input  wire       ev_protection,
   input  wire       ev_dma_last,
   input  wire       ev_ecc_error,
   // Output
   output reg        irq_n
);
   reg       pend_q;
   reg [3:0] pulse_q;
   reg       ev;
   always @* begin
      case (irq_source_sel)
         `FDHP_SRC_READY:    ev = ev_flash_ready;
         `FDHP_SRC_PROT:     ev = ev_protection;
         `FDHP_SRC_DMA_LAST: ev = ev_dma_last;
         default:            ev = ev_ecc_error;
      endcase
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q  <= 1'b0;
         pulse_q <= 4'h0;
         irq_n   <= 1'b1;
      end else begin
         // Set wins over acknowledge in the same cycle.
         if (ev) begin
            pend_q <= 1'b1;
         end else if (irq_ack) begin
            pend_q <= 1'b0;
         end
         // The event cycle itself is the first cycle of the pulse.
         if (ev) begin
            pulse_q <= `FDHP_IRQ_PULSE - 4'h1;
         end else if (pulse_q != 4'h0) begin
            pulse_q <= pulse_q - 4'h1;
         end
         if (irq_level_mode) begin
            irq_n <= ~(pend_q | ev);
         end else begin
            irq_n <= ~(ev | (pulse_q != 4'h0));
         end
      end
   end
endmodule // fdhp_irq
`default_nettype wire

// file: tb/fdhp_port_monitor.sv
`default_nettype none
// ---
// Checker on the port pins.
// ---
module fdhp_port_monitor #(
   parameter int AW = 13
) (
   // Clock and reset
   input wire logic          clk,
   input wire logic          rst,
   // Host pins
   input wire logic [AW-1:0] addr_pins,
   input wire logic          chip_select_n,
   input wire logic          data_oe_n,
   input wire logic          bus_width_16,
   input wire logic          key_guard,
   input wire logic          ready_wait_n,
   input wire logic          transfer_request_n,
   input wire logic          irq_n,
   // Core side
   input wire logic          load_done,
   input wire logic          dma_req,
   input wire logic          irq_level_mode,
   input wire logic          core_rd,
   input wire logic          deep_sleep_ctl,
   input wire logic          key_open_allowed,
   input wire logic          wide_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   ready_load_a: assert property ($rose(ready_wait_n) |-> load_done)
      else $error("ready without load");
   oe_release_a: assert property ($rose(chip_select_n) |-> ##[1:8] data_oe_n)
      else $error("drive after deselect");
   rd_pulse_a: assert property (core_rd |=> !core_rd)
      else $error("read pulse too long");
   rd_drive_a: assert property (core_rd |-> ##[1:2] !data_oe_n)
      else $error("read not driven");
   width_mode_a: assert property ($stable(bus_width_16) [*8] |-> wide_mode == bus_width_16)
      else $error("width strap ignored");
   sleep_req_a: assert property ((chip_select_n && addr_pins[0]) [*8] |-> deep_sleep_ctl)
      else $error("sleep request lost");
   key_lock_a: assert property ($stable(key_guard) [*8] |-> key_open_allowed == key_guard)
      else $error("key guard ignored");
   dma_req_a: assert property ((dma_req && ready_wait_n) [*3] |-> !transfer_request_n)
      else $error("transfer request missing");
   irq_pulse_a: assert property ($fell(irq_n) && !irq_level_mode |-> !irq_n [*4] ##1 irq_n)
      else $error("irq pulse width");
endmodule // fdhp_port_monitor
bind fdhp_port fdhp_port_monitor #(.AW(AW)) mon_u (
   .clk, .rst, .addr_pins, .chip_select_n, .data_oe_n, .bus_width_16, .key_guard,
   .ready_wait_n, .transfer_request_n, .irq_n, .load_done, .dma_req, .irq_level_mode,
   .core_rd, .deep_sleep_ctl, .key_open_allowed, .wide_mode
);
`default_nettype wire

// file: tb/fdhp_host_model.sv
`default_nettype none
// ---
// Host memory controller model.
// ---
module fdhp_host_model (
   // Clock
   input wire logic         clk,
   // Device outputs
   input wire logic         ready_wait_n,
   input wire logic         data_oe_n,
   input wire logic [15:0]  data_out,
   // Bus drive
   output var logic         chip_select_n,
   output var logic         read_strobe_n,
   output var logic         write_strobe_n,
   output var logic [12:0]  addr_pins,
   output wire logic [15:0] data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] host_d = 16'h0;
   logic [15:0] last_d = 16'h0;
   logic        host_oe = 1'b0;
   initial begin
      chip_select_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      addr_pins = 13'h0;
   end
   // A released bus shows a changing pattern, never the last value.
   assign data_in = !data_oe_n ? data_out : host_oe ? host_d : ~last_d;
   always @(posedge clk) last_d <= data_in;
   task automatic access(input logic stall, input logic cs, input logic wr,
                         input logic [12:0] a, input logic [15:0] wd, output logic [15:0] rd);
      int n;
      n = 0;
      while (stall && ready_wait_n !== 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      addr_pins <= a;
      host_d <= wd;
      host_oe <= wr;
      chip_select_n <= !cs;
      if (wr) write_strobe_n <= 1'b0;
      else read_strobe_n <= 1'b0;
      repeat (10) @(posedge clk);
      rd = data_in;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      repeat (4) @(posedge clk);
      chip_select_n <= 1'b1;
      host_oe <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule // fdhp_host_model
`default_nettype wire

// file: tb/tb_flash_disk_host_bus_port.sv
`default_nettype none
module tb_flash_disk_host_bus_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, power_on_reset_n = 1'b0, load_done = 1'b0;
   logic bus_width_16 = 1'b1, key_guard = 1'b0, dma_req = 1'b0;
   logic irq_level_mode = 1'b0, irq_ack = 1'b0;
   logic burst_clk = 1'b0;
   int burst_cnt = 0;
   logic [1:0] cascade_position_straps = 2'h0, irq_source_sel = 2'h0, target_position = 2'h0;
   logic [3:0] ev = 4'h0;
   logic [15:0] core_rdata = 16'h0, seed = 16'h8F21, rd;
   logic [44:0] e;
   logic [44:0] exp_q[$];
   int error_cnt = 0, check_count = 0, n;
   wire [12:0] addr_pins, core_addr;
   wire [15:0] data_in, data_out, core_wdata;
   wire data_oe_n, chip_select_n, read_strobe_n, write_strobe_n, ready_wait_n, irq_n;
   wire transfer_request_n, core_rd, core_wr, burst_tick, deep_sleep_ctl;
   wire key_open_allowed, mux_mode, wide_mode;
   initial forever #5 clk = ~clk;
   fdhp_port #(.LOAD_NS(200)) dut_u (
      .clk, .rst, .power_on_reset_n, .addr_pins, .data_in, .data_out, .data_oe_n,
      .chip_select_n, .read_strobe_n, .write_strobe_n, .burst_clk, .bus_width_16,
      .cascade_position_straps, .key_guard, .ready_wait_n, .transfer_request_n, .irq_n,
      .load_done, .dma_req, .core_rdata, .irq_source_sel, .irq_level_mode, .irq_ack,
      .ev_flash_ready(ev[0]), .ev_protection(ev[1]), .ev_dma_last(ev[2]),
      .ev_ecc_error(ev[3]), .target_position, .core_addr, .core_wdata, .core_rd, .core_wr,
      .burst_tick, .deep_sleep_ctl, .key_open_allowed, .mux_mode, .wide_mode
   );
   fdhp_host_model host_u (
      .clk, .ready_wait_n, .data_oe_n, .data_out, .chip_select_n, .read_strobe_n,
      .write_strobe_n, .addr_pins, .data_in
   );
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string what, input logic [15:0] x, input logic [15:0] s);
      check_count++;
      if (s !== x) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, x, s);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic xfer(input logic wr, input logic a0, input logic ok, input logic cs);
      logic [12:0] a;
      logic [15:0] r;
      seed = lfsr(seed);
      a = {seed[12:1], a0};
      r = seed ^ 16'h5A5A;
      core_rdata <= r;
      if (ok) exp_q.push_back({wr, a, seed, 15'h0});
      host_u.access(1'b1, cs, wr, a, seed, rd);
      if (ok && !wr && bus_width_16) chk("rdata", r, rd);
      if (ok && !wr && !bus_width_16) chk("byte", {8'h0, a0 ? r[15:8] : r[7:0]}, {8'h0, rd[7:0]});
   endtask
   task automatic pulse(input int k);
      ev <= 4'h1 << (k % 4);
      @(posedge clk);
      ev <= 4'h0;
   endtask
   // Each core access is paired with the oldest note left by the driver.
   always @(posedge clk) begin
      if (burst_tick === 1'b1) burst_cnt++;
      if (core_rd === 1'b1 || core_wr === 1'b1) begin
         if (exp_q.size() == 0) chk("unexpected access", 16'h0, 16'h1);
         else begin
            e = exp_q.pop_front();
            chk("kind", {15'h0, e[44]}, {15'h0, core_wr});
            chk("addr", {3'h0, e[43:31]}, {3'h0, core_addr});
            if (e[44]) chk("wdata", e[30:15], core_wdata);
         end
      end
   end
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      chk("ready", 16'h0, {15'h0, ready_wait_n});
      chk("oe", 16'h1, {15'h0, data_oe_n});
      host_u.access(1'b0, 1'b1, 1'b0, 13'h0004, 16'h0, rd);
      power_on_reset_n <= 1'b1;
      load_done <= 1'b1;
      xfer(1'b0, 1'b0, 1'b1, 1'b1);
      xfer(1'b1, 1'b0, 1'b1, 1'b1);
      xfer(1'b0, 1'b0, 1'b0, 1'b0);
      bus_width_16 <= 1'b0;
      repeat (8) @(posedge clk);
      xfer(1'b0, 1'b0, 1'b1, 1'b1);
      xfer(1'b0, 1'b1, 1'b1, 1'b1);
      bus_width_16 <= 1'b1;
      cascade_position_straps <= 2'h2;
      target_position <= 2'h1;
      repeat (8) @(posedge clk);
      xfer(1'b0, 1'b0, 1'b0, 1'b1);
      target_position <= 2'h2;
      xfer(1'b0, 1'b0, 1'b1, 1'b1);
      fork
         xfer(1'b0, 1'b0, 1'b1, 1'b1);
         begin
            repeat (3) @(posedge clk);
            repeat (2) begin
               burst_clk <= 1'b1;
               repeat (2) @(posedge clk);
               burst_clk <= 1'b0;
               repeat (2) @(posedge clk);
            end
         end
      join
      chk("burst ticks", 16'h2, burst_cnt[15:0]);
      for (int i = 0; i < 4; i++) begin
         irq_source_sel <= i[1:0];
         irq_level_mode <= i[0];
         key_guard <= i[1];
         dma_req <= i[0];
         repeat (10) @(posedge clk);
         pulse(i + 1);
         repeat (12) @(posedge clk);
         chk("quiet irq", 16'h1, {15'h0, irq_n});
         pulse(i);
         n = 0;
         while (irq_n !== 1'b0 && n < 12) begin
            @(posedge clk);
            n++;
         end
         chk("irq", 16'h0, {15'h0, irq_n});
         if (i[0]) begin
            repeat (8) @(posedge clk);
            chk("level irq", 16'h0, {15'h0, irq_n});
         end
         irq_ack <= 1'b1;
         @(posedge clk);
         irq_ack <= 1'b0;
         repeat (12) @(posedge clk);
         chk("irq idle", 16'h1, {15'h0, irq_n});
      end
      power_on_reset_n <= 1'b0;
      repeat (10) @(posedge clk);
      power_on_reset_n <= 1'b1;
      repeat (40) @(posedge clk);
      chk("std mode", 16'h0, {15'h0, mux_mode});
      cascade_position_straps <= 2'h0;
      repeat (10) @(posedge clk);
      cascade_position_straps <= 2'h2;
      repeat (10) @(posedge clk);
      chk("mux mode", 16'h1, {15'h0, mux_mode});
      target_position <= 2'h0;
      seed = lfsr(seed);
      host_u.host_d <= seed;
      host_u.host_oe <= 1'b1;
      cascade_position_straps <= 2'h0;
      repeat (8) @(posedge clk);
      cascade_position_straps <= 2'h2;
      @(posedge clk);
      host_u.host_oe <= 1'b0;
      core_rdata <= ~seed;
      exp_q.push_back({1'b0, seed[12:0], 16'h0, 15'h0});
      host_u.access(1'b1, 1'b1, 1'b0, ~seed[12:0], 16'h0, rd);
      chk("mux rdata", ~seed, rd);
      chk("notes left", 16'h0, 16'(exp_q.size()));
      report_and_stop();
   end
endmodule // tb_flash_disk_host_bus_port
`default_nettype wire
